//--- design/apc_codec.sv
/*
 * advertising payload structure codec: holds advertising and scan-response
 * payloads, pads them, streams the significant part to packet logic, and
 * parses a received payload into decoded fields and structure events.
 * assumes host and link-layer logic run on CLK; all ports same domain.
 */
// Summary of operation
// - advertising and scan-response payloads each held in 31-octet buffers.
// - each structure starts with one length octet covering following octets.
// - counted octets begin with type code, then that type's data.
// - octets after the last structure are zero in the buffer.
// - parser stops at a zero length octet, treating it as early end.
// - transmit only up to end of last structure, no padding.
// - advertising payload for three advertising packets, scan payload for scan response.
// - flags type 0x01 decoded into five discovery and capability bits.
// - flags never in scan response; a second flags is a format violation.
// - types 0x02,0x03 16-bit lists; 0x06,0x07 128-bit lists.
// - type 0x08 shortened name, 0x09 complete name.
// - type 0x0a one signed transmit power octet, -127 to +127 dBm.
// - 0x0d 3-octet class, 0x0e 16-octet hash, 0x0f 16-octet randomizer.
// - type 0x10 carries a 128-bit temporary pairing key.
// - type 0x11 out-of-band flags decoded into four bits.
// - type 0x12 minimum then maximum interval, 1.25 ms units.
// - interval bounds valid 0x0006 to 0x0c80; 0xffff means no preference.
// - types 0x14 and 0x15 solicitation lists, 16-bit and 128-bit.
// - type 0x16 16-bit service identifier then service data.
// - type 0xff company identifier in first two octets, then content.
`timescale 1ns/100ps
module apc_codec #(
    parameter int PLEN = apc_pkg::PAY_LEN
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic WR_EN,
    input wire logic WR_SCAN,
    input wire logic [4:0] WR_ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_CLEAR,
    input wire logic TX_START,
    input wire apc_pkg::apc_pdu_t TX_PDU,
    input wire logic TX_READY,
    output apc_pkg::apc_tx_t TX_OUT,
    output logic TX_BUSY,
    input wire logic RX_START,
    input wire logic RX_SCAN,
    input wire logic [PLEN*8-1:0] RX_PAYLOAD,
    output logic RX_BUSY,
    output logic RX_DONE,
    output logic RX_MALFORMED,
    output logic RX_FLAGS_VIOL,
    output logic RX_CI_BAD,
    output logic RX_TXPWR_BAD,
    output logic RX_STRUCT_VALID,
    output apc_pkg::apc_struct_t RX_STRUCT,
    output apc_pkg::apc_info_t RX_INFO
);
    // ****************
    // payload storage
    // ****************
    logic [PLEN*8-1:0] adv_buf_r;
    logic [PLEN*8-1:0] scan_buf_r;

    // writes refused mid stream
    // fixed 31-octet buffers
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            adv_buf_r <= '0;
            scan_buf_r <= '0;
        end else if (WR_CLEAR && !TX_BUSY) begin
            if (WR_SCAN) begin
                scan_buf_r <= '0;
            end else begin
                adv_buf_r <= '0;
            end
        end else if (WR_EN && !TX_BUSY && 32'(WR_ADDR) < PLEN) begin
            if (WR_SCAN) begin
                scan_buf_r[WR_ADDR*8 +: 8] <= WR_DATA;
            end else begin
                adv_buf_r[WR_ADDR*8 +: 8] <= WR_DATA;
            end
        end
    end

    // ****************
    // transmit side
    // ****************
    typedef enum logic [1:0] {APC_TX_IDLE, APC_TX_SEND, APC_TX_LAST} apc_tx_st_t;
    apc_tx_st_t tx_st_r;
    logic [5:0] tx_idx_r;
    logic [5:0] tx_len_r;
    logic tx_scan_r;
    logic [5:0] adv_sig;
    logic [5:0] scan_sig;
    logic [7:0] tx_octet;

    apc_tx_len u_adv_len (
        .payload(adv_buf_r),
        .sig_len(adv_sig)
    );
    apc_tx_len u_scan_len (
        .payload(scan_buf_r),
        .sig_len(scan_sig)
    );

    assign tx_octet = tx_scan_r ? scan_buf_r[tx_idx_r*8 +: 8] : adv_buf_r[tx_idx_r*8 +: 8];

    function automatic logic is_scan(input apc_pkg::apc_pdu_t p);
        is_scan = (p == apc_pkg::APC_PDU_SCAN_RSP);
    endfunction

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            tx_st_r <= APC_TX_IDLE;
            tx_idx_r <= 6'h00;
            tx_len_r <= 6'h00;
            tx_scan_r <= 1'b0;
            TX_OUT <= '0;
            TX_BUSY <= 1'b0;
        end else begin
            case (tx_st_r)
                APC_TX_IDLE: begin
                    TX_OUT <= '0;
                    if (TX_START) begin
                        tx_scan_r <= is_scan(TX_PDU);
                        tx_len_r <= is_scan(TX_PDU) ? scan_sig : adv_sig;
                        tx_idx_r <= 6'h00;
                        TX_OUT.pdu <= TX_PDU;
                        TX_BUSY <= 1'b1;
                        tx_st_r <= APC_TX_SEND;
                    end
                end
                APC_TX_SEND: begin
                    if (tx_len_r == 6'h00) begin
                        TX_OUT <= '0;
                        TX_BUSY <= 1'b0;
                        tx_st_r <= APC_TX_IDLE;
                    end else if (!TX_OUT.valid || TX_READY) begin
                        TX_OUT.valid <= 1'b1;
                        TX_OUT.first <= (tx_idx_r == 6'h00);
                        TX_OUT.last <= (tx_idx_r + 6'h01 == tx_len_r);
                        TX_OUT.data <= tx_octet;
                        tx_idx_r <= tx_idx_r + 6'h01;
                        if (tx_idx_r + 6'h01 == tx_len_r) begin
                            tx_st_r <= APC_TX_LAST;
                        end
                    end
                end
                APC_TX_LAST: begin
                    if (TX_READY) begin
                        TX_OUT <= '0;
                        TX_BUSY <= 1'b0;
                        tx_st_r <= APC_TX_IDLE;
                    end
                end
                default: tx_st_r <= APC_TX_IDLE;
            endcase
        end
    end

    // ****************
    // receive parser
    // ****************
    typedef enum logic [1:0] {APC_RX_IDLE, APC_RX_WALK, APC_RX_END} apc_rx_st_t;
    apc_rx_st_t rx_st_r;
    logic [PLEN*8-1:0] rx_buf_r;
    logic [5:0] rx_pos_r;
    logic rx_scan_r;
    logic rx_seen_flags_r;
    logic [7:0] cur_len;
    logic [7:0] cur_type;
    logic [5:0] dstart;
    logic [4:0] dlen;
    logic overrun;
    logic k_known;
    logic k_u16;
    logic k_u128;
    logic k_sol;
    logic k_cmp;
    logic k_name;
    logic [7:0] d0;
    logic [15:0] ci_lo;
    logic [15:0] ci_hi;

    // ****************
    // field helpers
    // ****************
    function automatic logic [7:0] rx_oct(input logic [PLEN*8-1:0] b, input logic [5:0] i);
        rx_oct = (32'(i) < PLEN) ? b[i*8 +: 8] : 8'h00;
    endfunction

    function automatic logic [15:0] rx_u16(input logic [PLEN*8-1:0] b, input logic [5:0] i);
        rx_u16 = {rx_oct(b, i + 6'h01), rx_oct(b, i)};
    endfunction

    function automatic logic [127:0] rx_u128(input logic [PLEN*8-1:0] b, input logic [5:0] i);
        logic [127:0] v;
        v = '0;
        for (int k = 0; k < 16; k++) begin
            v[k*8 +: 8] = rx_oct(b, 6'(32'(i) + k));
        end
        rx_u128 = v;
    endfunction

    function automatic logic ci_ok(input logic [15:0] v);
        ci_ok = (v >= apc_pkg::CI_MIN && v <= apc_pkg::CI_MAX) || v == apc_pkg::CI_NOPREF;
    endfunction

    assign cur_len = rx_oct(rx_buf_r, rx_pos_r);
    // type code leads the counted octets
    assign cur_type = rx_oct(rx_buf_r, rx_pos_r + 6'h01);
    assign dstart = rx_pos_r + 6'h02;
    assign dlen = 5'(cur_len - 8'h01);
    assign overrun = 9'(rx_pos_r) + 9'(cur_len) > 9'(apc_pkg::LAST_IDX);
    // first data octet
    assign d0 = rx_oct(rx_buf_r, dstart);
    // interval bounds
    assign ci_lo = rx_u16(rx_buf_r, dstart);
    assign ci_hi = rx_u16(rx_buf_r, dstart + 6'h02);

    apc_type_dec u_dec (
        .type_code(cur_type),
        .known(k_known),
        .uuid16(k_u16),
        .uuid128(k_u128),
        .solicit(k_sol),
        .complete(k_cmp),
        .name(k_name)
    );

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rx_st_r <= APC_RX_IDLE;
            rx_buf_r <= '0;
            rx_pos_r <= 6'h00;
            rx_scan_r <= 1'b0;
            rx_seen_flags_r <= 1'b0;
            RX_BUSY <= 1'b0;
            RX_DONE <= 1'b0;
            RX_MALFORMED <= 1'b0;
            RX_FLAGS_VIOL <= 1'b0;
            RX_CI_BAD <= 1'b0;
            RX_TXPWR_BAD <= 1'b0;
            RX_STRUCT_VALID <= 1'b0;
            RX_STRUCT <= '0;
            RX_INFO <= '0;
        end else begin
            RX_DONE <= 1'b0;
            RX_STRUCT_VALID <= 1'b0;
            case (rx_st_r)
                APC_RX_IDLE: begin
                    if (RX_START) begin
                        rx_buf_r <= RX_PAYLOAD;
                        rx_scan_r <= RX_SCAN;
                        rx_pos_r <= 6'h00;
                        rx_seen_flags_r <= 1'b0;
                        RX_BUSY <= 1'b1;
                        RX_MALFORMED <= 1'b0;
                        RX_FLAGS_VIOL <= 1'b0;
                        RX_CI_BAD <= 1'b0;
                        RX_TXPWR_BAD <= 1'b0;
                        RX_INFO <= '0;
                        rx_st_r <= APC_RX_WALK;
                    end
                end
                APC_RX_WALK: begin
                    if (32'(rx_pos_r) >= PLEN || cur_len == apc_pkg::PAD_OCTET) begin
                        rx_st_r <= APC_RX_END;
                    end else if (overrun) begin
                        RX_MALFORMED <= 1'b1;
                        rx_st_r <= APC_RX_END;
                    end else begin
                        RX_STRUCT_VALID <= 1'b1;
                        RX_STRUCT <= {cur_type, 5'(dstart), dlen, k_known, k_u16, k_u128,
                                      k_sol, k_cmp, k_name};
                        case (cur_type)
                            apc_pkg::T_FLAGS: begin
                                if (rx_scan_r || rx_seen_flags_r) begin
                                    RX_FLAGS_VIOL <= 1'b1;
                                end else begin
                                    RX_INFO.flags <= d0[4:0];
                                end
                                rx_seen_flags_r <= 1'b1;
                            end
                            apc_pkg::T_TXPWR: begin
                                RX_INFO.tx_power <= d0;
                                if (d0 == 8'h80) begin
                                    RX_TXPWR_BAD <= 1'b1;
                                end
                            end
                            apc_pkg::T_DEV_CLASS: RX_INFO.dev_class <=
                                {rx_oct(rx_buf_r, dstart + 6'h02), rx_u16(rx_buf_r, dstart)};
                            apc_pkg::T_PAIR_HASH: RX_INFO.pair_hash <= rx_u128(rx_buf_r, dstart);
                            apc_pkg::T_PAIR_RAND: RX_INFO.pair_rand <= rx_u128(rx_buf_r, dstart);
                            apc_pkg::T_TEMP_KEY: RX_INFO.temp_key <= rx_u128(rx_buf_r, dstart);
                            apc_pkg::T_OOB_FLAGS: RX_INFO.oob_flags <=
                                d0[3:0];
                            apc_pkg::T_CONN_INT: begin
                                RX_INFO.ci_min <= ci_lo;
                                RX_INFO.ci_max <= ci_hi;
                                RX_INFO.ci_min_valid <= ci_ok(ci_lo);
                                RX_INFO.ci_max_valid <= ci_ok(ci_hi);
                                if (!ci_ok(ci_lo) ||
                                    !ci_ok(ci_hi)) begin
                                    RX_CI_BAD <= 1'b1;
                                end
                            end
                            apc_pkg::T_SVC_DATA: RX_INFO.svc_data_id <= rx_u16(rx_buf_r, dstart);
                            apc_pkg::T_MAKER: RX_INFO.company_id <= rx_u16(rx_buf_r, dstart);
                            default: ;
                        endcase
                        rx_pos_r <= 6'(7'(rx_pos_r) + 7'(cur_len) + 7'h01);
                    end
                end
                APC_RX_END: begin
                    RX_BUSY <= 1'b0;
                    RX_DONE <= 1'b1;
                    rx_st_r <= APC_RX_IDLE;
                end
                default: rx_st_r <= APC_RX_IDLE;
            endcase
        end
    end
endmodule

//--- design/apc_pkg.sv
/*
 * package for the advertising payload structure codec: sizes, type codes,
 * flag bit positions, interval limits, packet kinds and carrier structs.
 * assumes nothing of its surroundings.
 */
package apc_pkg;
    localparam int PAY_LEN = 31;
    localparam int IDX_W = 5;
    localparam logic [4:0] LAST_IDX = 5'h1e;
    localparam logic [7:0] PAD_OCTET = 8'h00;
    localparam logic [7:0] T_FLAGS = 8'h01;
    localparam logic [7:0] T_U16_INC = 8'h02;
    localparam logic [7:0] T_U16_CMP = 8'h03;
    localparam logic [7:0] T_U128_INC = 8'h06;
    localparam logic [7:0] T_U128_CMP = 8'h07;
    localparam logic [7:0] T_NAME_SHORT = 8'h08;
    localparam logic [7:0] T_NAME_FULL = 8'h09;
    localparam logic [7:0] T_TXPWR = 8'h0a;
    localparam logic [7:0] T_DEV_CLASS = 8'h0d;
    localparam logic [7:0] T_PAIR_HASH = 8'h0e;
    localparam logic [7:0] T_PAIR_RAND = 8'h0f;
    localparam logic [7:0] T_TEMP_KEY = 8'h10;
    localparam logic [7:0] T_OOB_FLAGS = 8'h11;
    localparam logic [7:0] T_CONN_INT = 8'h12;
    localparam logic [7:0] T_SOL_U16 = 8'h14;
    localparam logic [7:0] T_SOL_U128 = 8'h15;
    localparam logic [7:0] T_SVC_DATA = 8'h16;
    localparam logic [7:0] T_MAKER = 8'hff;
    localparam logic [7:0] TXPWR_MIN = 8'h81;
    localparam logic [15:0] CI_MIN = 16'h0006;
    localparam logic [15:0] CI_MAX = 16'h0c80;
    localparam logic [15:0] CI_NOPREF = 16'hffff;
    localparam int FLG_LIM = 0;
    localparam int FLG_GEN = 1;
    localparam int FLG_NOCLASSIC = 2;
    localparam int FLG_SIM_CTL = 3;
    localparam int FLG_SIM_HOST = 4;
    localparam int OOB_PRESENT = 0;
    localparam int OOB_LE_HOST = 1;
    localparam int OOB_SIM_HOST = 2;
    localparam int OOB_ADDR_RND = 3;

    typedef enum logic [1:0] {
        APC_PDU_ADV_IND,
        APC_PDU_NONCONN,
        APC_PDU_SCAN_IND,
        APC_PDU_SCAN_RSP
    } apc_pdu_t;

    // decoded content of one payload
    typedef struct packed {
        logic [4:0] flags;
        logic [3:0] oob_flags;
        logic [7:0] tx_power;
        logic [15:0] ci_min;
        logic [15:0] ci_max;
        logic ci_min_valid;
        logic ci_max_valid;
        logic [15:0] company_id;
        logic [15:0] svc_data_id;
        logic [23:0] dev_class;
        logic [127:0] temp_key;
        logic [127:0] pair_hash;
        logic [127:0] pair_rand;
    } apc_info_t;

    // one decoded structure event
    typedef struct packed {
        logic [7:0] ad_type;
        logic [4:0] data_start;
        logic [4:0] data_len;
        logic known;
        logic uuid16;
        logic uuid128;
        logic solicit;
        logic complete;
        logic name;
    } apc_struct_t;

    // transmit octet stream
    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic [7:0] data;
        apc_pdu_t pdu;
    } apc_tx_t;
endpackage

//--- design/apc_type_dec.sv
/*
 * combinational classifier of a structure type code.
 * assumes type code taken from a stable buffer octet.
 */
`timescale 1ns/100ps
module apc_type_dec (
    input wire logic [7:0] type_code,
    output logic known,
    output logic uuid16,
    output logic uuid128,
    output logic solicit,
    output logic complete,
    output logic name
);
    always_comb begin
        known = 1'b1;
        uuid16 = 1'b0;
        uuid128 = 1'b0;
        solicit = 1'b0;
        complete = 1'b0;
        name = 1'b0;
        case (type_code)
            apc_pkg::T_U16_INC: uuid16 = 1'b1;
            apc_pkg::T_U16_CMP: begin
                uuid16 = 1'b1;
                complete = 1'b1;
            end
            apc_pkg::T_U128_INC: uuid128 = 1'b1;
            apc_pkg::T_U128_CMP: begin
                uuid128 = 1'b1;
                complete = 1'b1;
            end
            apc_pkg::T_NAME_SHORT: name = 1'b1;
            apc_pkg::T_NAME_FULL: begin
                name = 1'b1;
                complete = 1'b1;
            end
            apc_pkg::T_SOL_U16: begin
                uuid16 = 1'b1;
                solicit = 1'b1;
            end
            apc_pkg::T_SOL_U128: begin
                uuid128 = 1'b1;
                solicit = 1'b1;
            end
            apc_pkg::T_FLAGS, apc_pkg::T_TXPWR, apc_pkg::T_DEV_CLASS,
            apc_pkg::T_PAIR_HASH, apc_pkg::T_PAIR_RAND, apc_pkg::T_TEMP_KEY,
            apc_pkg::T_OOB_FLAGS, apc_pkg::T_CONN_INT, apc_pkg::T_SVC_DATA,
            apc_pkg::T_MAKER: known = 1'b1;
            default: known = 1'b0;
        endcase
    end
endmodule

//--- design/apc_tx_len.sv
/*
 * finds the significant length of a 31-octet payload by walking the
 * length octets. assumes the payload is stable while in use.
 */
`timescale 1ns/100ps
module apc_tx_len (
    input wire logic [apc_pkg::PAY_LEN*8-1:0] payload,
    output logic [5:0] sig_len
);
    always_comb begin
        logic [5:0] pos;
        logic stop;
        logic [7:0] ln;
        pos = 6'h00;
        stop = 1'b0;
        ln = 8'h00;
        sig_len = 6'h00;
        for (int i = 0; i < apc_pkg::PAY_LEN; i++) begin
            if (!stop && pos < 6'(apc_pkg::PAY_LEN)) begin
                ln = payload[pos*8 +: 8];
                if (ln == apc_pkg::PAD_OCTET ||
                    9'(pos) + 9'(ln) >= 9'(apc_pkg::PAY_LEN)) begin
                    stop = 1'b1;
                end else begin
                    pos = 6'(7'(pos) + 7'(ln) + 7'h01);
                    sig_len = pos;
                end
            end
        end
    end
endmodule

//--- sim/apc_codec_properties.sv
/* checker for apc_codec ports.
   assumes binding into apc_codec. */
`timescale 1ns/100ps
module apc_codec_properties (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic TX_START,
    input wire logic TX_READY,
    input wire apc_pkg::apc_tx_t TX_OUT,
    input wire logic TX_BUSY,
    input wire logic RX_START,
    input wire logic RX_BUSY,
    input wire logic RX_DONE,
    input wire logic RX_STRUCT_VALID,
    input wire logic RX_MALFORMED,
    input wire logic RX_FLAGS_VIOL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // ****************
    // stream and parse relations
    // ****************
    property p_tx_go; TX_START && !TX_BUSY |=> TX_BUSY; endproperty
    a_tx_go: assert property (p_tx_go) else $error("no busy");
    property p_tx_hold; TX_OUT.valid && !TX_READY |=> TX_OUT.valid && $stable(TX_OUT.data); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("stall drop");
    property p_tx_in; TX_OUT.valid |-> TX_BUSY; endproperty
    a_tx_in: assert property (p_tx_in) else $error("idle octet");
    property p_tx_first; $rose(TX_OUT.valid) |-> TX_OUT.first; endproperty
    a_tx_first: assert property (p_tx_first) else $error("no first");
    property p_tx_end; TX_OUT.valid && TX_OUT.last && TX_READY |=> !TX_OUT.valid && !TX_BUSY; endproperty
    a_tx_end: assert property (p_tx_end) else $error("past last");
    property p_rx_go; RX_START && !RX_BUSY |=> RX_BUSY && !RX_MALFORMED && !RX_FLAGS_VIOL; endproperty
    a_rx_go: assert property (p_rx_go) else $error("bad start");
    property p_rx_span; RX_START && !RX_BUSY |-> ##[3:20] RX_DONE; endproperty
    a_rx_span: assert property (p_rx_span) else $error("no done");
    property p_rx_pulse; RX_DONE |-> !RX_BUSY ##1 !RX_DONE; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("done pulse");
    property p_rx_struct; RX_STRUCT_VALID |-> RX_BUSY && !RX_DONE; endproperty
    a_rx_struct: assert property (p_rx_struct) else $error("stray struct");
    property p_rx_keep; !RX_BUSY && !RX_START |=> $stable(RX_MALFORMED) && $stable(RX_FLAGS_VIOL);
    endproperty
    a_rx_keep: assert property (p_rx_keep) else $error("idle flag move");
endmodule
bind apc_codec apc_codec_properties u_props (.CLK, .NRST, .TX_START, .TX_READY, .TX_OUT,
    .TX_BUSY, .RX_START, .RX_BUSY, .RX_DONE, .RX_STRUCT_VALID, .RX_MALFORMED, .RX_FLAGS_VIOL);

//--- sim/apc_link_model.sv
/* link side model: logs the transmit octets.
   assumes codec clock; slow stalls ready 3 cycles in 4. */
`timescale 1ns/100ps
module apc_link_model (
    input wire logic clk,
    input wire logic slow,
    input wire apc_pkg::apc_tx_t tx_in,
    output logic ready
);
    logic [11:0] got[$];
    logic [1:0] ph_r = 2'h0;
    always @(posedge clk) begin
        ph_r <= ph_r + 2'h1;
        if (tx_in.valid && ready) begin
            got.push_back({tx_in.pdu, tx_in.first, tx_in.last, tx_in.data});
        end
    end
    assign ready = !slow || ph_r == 2'h2;
endmodule

//--- sim/apc_codec_tb.sv
/* bench for apc_codec: random and hand payloads.
   assumes link model and checker compiled in. */
`timescale 1ns/100ps
module apc_codec_tb;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic WR_EN = 1'b0, WR_SCAN = 1'b0, WR_CLEAR = 1'b0, TX_START = 1'b0, TX_READY;
    logic [4:0] WR_ADDR = 5'h00;
    logic [7:0] WR_DATA = 8'h00;
    apc_pkg::apc_pdu_t TX_PDU = apc_pkg::APC_PDU_ADV_IND;
    apc_pkg::apc_tx_t TX_OUT;
    logic TX_BUSY, RX_BUSY, RX_DONE, RX_MALFORMED, RX_FLAGS_VIOL, RX_CI_BAD, RX_TXPWR_BAD;
    logic RX_START = 1'b0, RX_SCAN = 1'b0, RX_STRUCT_VALID, slow = 1'b0;
    logic [247:0] RX_PAYLOAD = '0;
    apc_pkg::apc_struct_t RX_STRUCT;
    apc_pkg::apc_info_t RX_INFO;
    int fails = 0, cmp_count = 0, cyc = 0;
    logic [7:0] types [19] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d,
        8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h14, 8'h15, 8'h16, 8'hff, 8'h2a};
    always #4 CLK = ~CLK;
    apc_codec i_dut (.CLK, .NRST, .WR_EN, .WR_SCAN, .WR_ADDR, .WR_DATA, .WR_CLEAR, .TX_START,
        .TX_PDU, .TX_READY, .TX_OUT, .TX_BUSY, .RX_START, .RX_SCAN, .RX_PAYLOAD, .RX_BUSY,
        .RX_DONE, .RX_MALFORMED, .RX_FLAGS_VIOL, .RX_CI_BAD, .RX_TXPWR_BAD, .RX_STRUCT_VALID,
        .RX_STRUCT, .RX_INFO);
    apc_link_model u_link (.clk(CLK), .slow(slow), .tx_in(TX_OUT), .ready(TX_READY));
    // ****************
    // helpers
    // ****************
    task automatic step();
        @(posedge CLK);
        #1;
    endtask
    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [247:0] mk(input logic [7:0] q[$]);
        logic [247:0] b = '0;
        foreach (q[i]) b[8*i+:8] = q[i];
        return b;
    endfunction
    function automatic logic [247:0] gen();
        logic [247:0] b = '0;
        int p = 0;
        int l;
        while (p < 29 && $urandom_range(5) != 0) begin
            l = $urandom_range(6, 1);
            if (p + l > 30) l = 30 - p;
            b[8*p+:8] = 8'(l);
            b[8*p+8+:8] = types[$urandom_range(18)];
            for (int i = 2; i <= l; i++) b[8*(p+i)+:8] = 8'($urandom);
            p = p + l + 1;
        end
        return b;
    endfunction
    function automatic int slen(input logic [247:0] b);
        int p = 0;
        while (p < 31 && b[8*p+:8] != 0 && p + b[8*p+:8] <= 30) p = p + b[8*p+:8] + 1;
        return p;
    endfunction
    function automatic logic [5:0] cls(input logic [7:0] t);
        return {t != 8'h2a, t inside {8'h02, 8'h03, 8'h14}, t inside {8'h06, 8'h07, 8'h15},
            t inside {8'h14, 8'h15}, t inside {8'h03, 8'h07, 8'h09}, t inside {8'h08, 8'h09}};
    endfunction
    task automatic load(input logic scan, input logic [247:0] b);
        WR_SCAN = scan;
        WR_CLEAR = 1'b1;
        step();
        WR_CLEAR = 1'b0;
        for (int i = 0; i < 32; i++) begin
            WR_ADDR = 5'(i);
            WR_DATA = (i < 31) ? b[8*i+:8] : 8'hff;
            WR_EN = (i == 31) || (WR_DATA != 8'h00);
            step();
        end
        WR_EN = 1'b0;
    endtask
    task automatic tx(input apc_pkg::apc_pdu_t pdu, input logic [247:0] b);
        int n = slen(b);
        u_link.got.delete();
        TX_PDU = pdu;
        TX_START = 1'b1;
        step();
        TX_START = 1'b0;
        WR_ADDR = 5'h00;
        WR_DATA = 8'h00;
        for (int k = 0; k < 300 && TX_BUSY === 1'b1; k++) begin
            WR_EN = (k == 1);
            step();
        end
        WR_EN = 1'b0;
        chk("tx_count", u_link.got.size(), n);
        foreach (u_link.got[j]) chk("tx_octet", u_link.got[j], {pdu, j == 0, j == n - 1, b[8*j+:8]});
    endtask
    task automatic rx(input logic [247:0] b, input logic scan);
        int p = 0;
        int nf = 0;
        logic fv = 1'b0;
        logic [7:0] l;
        RX_PAYLOAD = b;
        RX_SCAN = scan;
        RX_START = 1'b1;
        step();
        RX_START = 1'b0;
        for (int k = 0; k < 30 && RX_DONE !== 1'b1; k++) begin
            step();
            if (RX_STRUCT_VALID === 1'b1 && p < 30) begin
                l = b[8*p+:8];
                chk("st_fits", p + l <= 30, 1'b1);
                chk("st_type", RX_STRUCT.ad_type, b[8*p+8+:8]);
                chk("st_pos", {RX_STRUCT.data_start, RX_STRUCT.data_len}, {5'(p + 2), 5'(l - 1)});
                chk("st_class", RX_STRUCT[5:0], cls(b[8*p+8+:8]));
                if (b[8*p+8+:8] == 8'h01) begin
                    fv = fv || scan || nf > 0;
                    nf++;
                end
                p = p + l + 1;
            end
        end
        chk("rx_done", RX_DONE, 1'b1);
        chk("viol", RX_FLAGS_VIOL, fv);
        chk("malformed", RX_MALFORMED, p < 31 && b[8*p+:8] != 8'h00);
    endtask
    // ****************
    // sequence
    // ****************
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        logic [247:0] a, s;
        logic [127:0] k;
        logic [383:0] w;
        apc_pkg::apc_pdu_t pd;
        void'($urandom(94));
        repeat (12) @(posedge CLK);
        #1 NRST = 1'b1;
        a = mk('{8'h02, 8'h01, 8'h06, 8'h02, 8'h0a, 8'h85, 8'h05, 8'h12, 8'h06, 8'h00, 8'hff,
            8'hff, 8'h03, 8'hff, 8'h34, 8'h12, 8'h02, 8'h01, 8'h1f, 8'h03, 8'h16, 8'hcd, 8'hab});
        load(1'b0, a);
        tx(apc_pkg::APC_PDU_ADV_IND, a);
        rx(a, 1'b0);
        chk("flags", RX_INFO.flags, 5'h06);
        chk("tx_power", RX_INFO.tx_power, 8'h85);
        chk("ci", {RX_INFO.ci_min, RX_INFO.ci_max, RX_INFO.ci_min_valid, RX_INFO.ci_max_valid,
            RX_CI_BAD}, {16'h0006, 16'hffff, 3'b110});
        chk("ids", {RX_INFO.company_id, RX_INFO.svc_data_id}, 32'h1234abcd);
        a = mk('{8'h05, 8'h12, 8'h05, 8'h00, 8'h81, 8'h0c, 8'h02, 8'h0a, 8'h80, 8'h04, 8'h0d,
            8'h01, 8'h02, 8'h03, 8'h02, 8'h11, 8'h0b});
        rx(a, 1'b1);
        chk("bad", {RX_CI_BAD, RX_TXPWR_BAD, RX_INFO.ci_min_valid, RX_INFO.ci_max_valid},
            4'b1100);
        chk("oob", {RX_INFO.dev_class, RX_INFO.oob_flags}, 28'h030201b);
        slow = 1'b1;
        a = mk('{8'h03, 8'h09, 8'h41, 8'h42, 8'h1e, 8'h2a});
        load(1'b1, a);
        tx(apc_pkg::APC_PDU_SCAN_RSP, a);
        rx(a, 1'b0);
        a = mk('{8'h02, 8'h01, 8'h06, 8'h00, 8'h05, 8'h09, 8'h41});
        load(1'b0, a);
        tx(apc_pkg::APC_PDU_NONCONN, a);
        rx(a, 1'b1);
        a = mk('{8'h1e, 8'hff, 8'h78, 8'h56});
        load(1'b0, a);
        tx(apc_pkg::APC_PDU_SCAN_IND, a);
        rx(a, 1'b0);
        a = mk('{8'h00});
        load(1'b0, a);
        tx(apc_pkg::APC_PDU_ADV_IND, a);
        rx(a, 1'b0);
        for (int t = 14; t < 17; t++) begin
            k = {$urandom, $urandom, $urandom, $urandom};
            rx(248'({k, 8'(t), 8'h11}), 1'b0);
            w = {RX_INFO.temp_key, RX_INFO.pair_rand, RX_INFO.pair_hash};
            chk("key", w[128*(t-14)+:128], k);
        end
        for (int i = 0; i < 30; i++) begin
            slow = 1'($urandom_range(1));
            a = gen();
            s = gen();
            load(1'b0, a);
            load(1'b1, s);
            pd = apc_pkg::apc_pdu_t'($urandom_range(3));
            tx(pd, pd == apc_pkg::APC_PDU_SCAN_RSP ? s : a);
            tx(pd, pd == apc_pkg::APC_PDU_SCAN_RSP ? s : a);
            rx(a, 1'($urandom_range(1)));
        end
        tally_and_finish();
    end
endmodule
